// [hcs_pkg.sv]
package hcs_pkg;

	// ============================================================
	// Sizes
	localparam int NUM_CTX   = 5;
	localparam int CTX_W     = 3;
	localparam int PRIO_W    = 3;
	localparam int NUM_IRQ   = 16;
	localparam int IRQ_W     = 4;
	localparam int ADDR_W    = 32;
	localparam int SW_W      = 16;

	// ============================================================
	// Fixed values
	localparam logic [CTX_W-1:0] MASTER_CTX = 3'h0;
	// Position of the supervisor bit in the status word
	localparam int SUPV_BIT = 13;
	localparam logic [PRIO_W-1:0] PRIO_RST = 3'h0;
	// Cycles for a single-thread switch
	localparam int ST_SWITCH_CYC = 1;

	// ============================================================
	// Types
	typedef enum logic [1:0] {
		TYPE_STANDARD,
		TYPE_FAST_VECT,
		TYPE_SINGLE_THREAD
	} hcs_ctx_type_t;

	typedef enum logic [1:0] {
		ST_READY,
		ST_NOT_READY,
		ST_HALTED
	} hcs_ctx_state_t;

	// One context's control word
	typedef struct packed {
		logic           enable;
		hcs_ctx_type_t  ctype;
		logic [PRIO_W-1:0] prio;
		logic           halt;
	} hcs_ctx_ctrl_t;

	localparam hcs_ctx_ctrl_t CTRL_RST = '{
		enable: 1'b0, ctype: TYPE_STANDARD, prio: PRIO_RST, halt: 1'b0};

	// Request to the execution unit
	typedef struct packed {
		logic              valid;
		logic [CTX_W-1:0]  ctx;
		logic              load_vec;
		logic              push_frame;
		logic [IRQ_W-1:0]  vec_num;
	} hcs_switch_t;

endpackage

// [hcs_pick.sv]
`timescale 1ns/1ps
`default_nettype none

// Picks the highest ranked candidate; lower index wins ties,
// index 0 always wins when it is a candidate.
module hcs_pick
	import hcs_pkg::*;
#(
	parameter int N = NUM_CTX
) (
	input  wire logic [N-1:0]             cand,
	input  wire logic [N-1:0][PRIO_W-1:0] prio,
	output logic                          found,
	output logic [CTX_W-1:0]              win
);

	// Refused at elaboration: every index must fit the index width
	if (N < 1 || N > (1 << CTX_W)) begin : g_bad_n
		$error("hcs_pick: unsupported context count");
	end

	logic [PRIO_W-1:0] best_p;

	always_comb begin
		found  = 1'b0;
		win    = MASTER_CTX;
		best_p = '0;
		if (cand[0]) begin
			found = 1'b1;
		end else begin
			for (int i = 1; i < N; i++) begin
				if (cand[i] && (!found || prio[i] > best_p)) begin
					found  = 1'b1;
					win    = CTX_W'(i);
					best_p = prio[i];
				end
			end
		end
	end

endmodule

`default_nettype wire

// [hcs_sched.sv]
`timescale 1ns/1ps
`default_nettype none

// Function
// - five contexts with private register sets share one execution unit
// - each context is standard, fast-vectored or single-thread type
// - each context is ready, not ready or halted
// - sleep moves running context from ready to not ready unless an irq is pending for it
// - standard: fetch vector; push and reload frame if irq outranks
// - fast-vectored: load program counter from vector, no stacking
// - fast-vectored accepts any number of irqs, each own vector
// - single-thread: resume at current counter, no vector, one cycle
// - each irq bound to one context with context-relative priority
// - context 0 always ranks highest
// - after reset execution starts in context 0
// - only master context may write context control words
// - other priorities programmable; equal priority lower index wins
// - protected fields written only by master in supervisor mode
// - halted context skipped until master write or debug release
// - unused contexts disabled, no effect on scheduling
// - switching never saves registers to memory
module hcs_sched
	import hcs_pkg::*;
#(
	parameter int N_CTX = NUM_CTX,
	parameter int N_IRQ = NUM_IRQ
) (
	input  wire logic                          mclk,
	input  wire logic                          rst_n,
	// Interrupt sources, one level each
	input  wire logic [N_IRQ-1:0]              irq_req,
	// Binding table: owning context and relative priority per source
	input  wire logic [N_IRQ-1:0][CTX_W-1:0]   irq_ctx,
	input  wire logic [N_IRQ-1:0][PRIO_W-1:0]  irq_prio,
	// Control word write from the execution unit
	input  wire logic                          ctl_we,
	input  wire logic [CTX_W-1:0]              ctl_idx,
	input  wire hcs_ctx_ctrl_t                 ctl_wdata,
	input  wire logic [SW_W-1:0]               cur_status_word,
	// Protected field write, e.g. master-only priority
	input  wire logic                          prot_we,
	input  wire logic [PRIO_W-1:0]             prot_wdata,
	// Execution unit events
	input  wire logic                          sleep_exec,
	input  wire logic                          irq_return,
	input  wire logic                          switch_ack,
	// Debug release of a halted context
	input  wire logic                          dbg_release,
	input  wire logic [CTX_W-1:0]              dbg_idx,
	output hcs_switch_t                        switch_req,
	output logic [CTX_W-1:0]                   run_ctx,
	output logic [N_CTX-1:0][1:0]              ctx_state,
	output logic [N_CTX-1:0][SW_W-1:0]         saved_frames,
	output logic [PRIO_W-1:0]                  prot_field,
	output logic                               write_blocked
);

	// Refused at elaboration: context counts beyond NUM_CTX, irq counts beyond the index width
	if (N_CTX < 1 || N_CTX > NUM_CTX) begin : g_bad_ctx
		$error("hcs_sched: context count not served");
	end
	if (N_IRQ < 1 || N_IRQ > (1 << IRQ_W)) begin : g_bad_irq
		$error("hcs_sched: irq count not served");
	end

	// ============================================================
	// Context state
	// per-context records, one execution unit
	hcs_ctx_ctrl_t  ctrl_q [N_CTX];
	hcs_ctx_state_t state_q [N_CTX];
	logic [CTX_W-1:0] run_q;
	logic [N_CTX-1:0] in_handler_q;
	logic [N_CTX-1:0][SW_W-1:0] depth_q;
	hcs_switch_t req_q;
	logic [PRIO_W-1:0] prot_q;
	logic blocked_q;

	logic master_run;
	logic supervisor;
	assign master_run = (run_q == MASTER_CTX);
	assign supervisor = cur_status_word[SUPV_BIT];

	// ============================================================
	// Debug port crossing
	// The debug port runs on its own clock, so the release passes two
	// flops; the index must stay steady while the release crosses
	logic             dbg_rel_meta_q;
	logic             dbg_rel_q;
	logic [CTX_W-1:0] dbg_idx_meta_q;
	logic [CTX_W-1:0] dbg_idx_q;

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			dbg_rel_meta_q <= 1'b0;
			dbg_rel_q      <= 1'b0;
			dbg_idx_meta_q <= MASTER_CTX;
			dbg_idx_q      <= MASTER_CTX;
		end else begin
			dbg_rel_meta_q <= dbg_release;
			dbg_rel_q      <= dbg_rel_meta_q;
			dbg_idx_meta_q <= dbg_idx;
			dbg_idx_q      <= dbg_idx_meta_q;
		end
	end

	// ============================================================
	// Interrupt routing
	logic [N_CTX-1:0] pend;
	logic [N_CTX-1:0][IRQ_W-1:0] pend_vec;
	logic [N_CTX-1:0][PRIO_W-1:0] pend_prio;

	always_comb begin
		pend      = '0;
		pend_vec  = '0;
		pend_prio = '0;
		// each source feeds only its bound context
		// many sources per context, best one keeps its vector
		for (int s = 0; s < N_IRQ; s++) begin
			for (int c = 0; c < N_CTX; c++) begin
				if (irq_req[s] && irq_ctx[s] == CTX_W'(c) &&
				    (!pend[c] || irq_prio[s] > pend_prio[c])) begin
					pend[c]      = 1'b1;
					pend_vec[c]  = IRQ_W'(s);
					pend_prio[c] = irq_prio[s];
				end
			end
		end
	end

	// ============================================================
	// Candidate selection
	logic [N_CTX-1:0] cand;
	logic [N_CTX-1:0][PRIO_W-1:0] rank;
	logic found;
	logic [CTX_W-1:0] win;

	genvar g;
	generate
		for (g = 0; g < N_CTX; g++) begin : g_cand
			// ready or pending irq makes a candidate
			assign cand[g] = ctrl_q[g].enable &&
			                 state_q[g] != ST_HALTED &&
			                 (state_q[g] == ST_READY || pend[g]);
			assign rank[g] = ctrl_q[g].prio;
			assign ctx_state[g] = state_q[g];
			assign saved_frames[g] = depth_q[g];
		end
	endgenerate

	hcs_pick #(
		.N(N_CTX)
	) u_pick (
		.cand  (cand),
		.prio  (rank),
		.found (found),
		.win   (win)
	);

	// Writes allowed to control words and protected fields
	logic ctl_ok;
	logic prot_ok;
	assign ctl_ok = ctl_we && master_run && ctl_idx < CTX_W'(N_CTX);
	// master in supervisor mode for protected fields
	assign prot_ok = prot_we && master_run && supervisor;

	// ============================================================
	// Control words
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			for (int c = 0; c < N_CTX; c++)
				ctrl_q[c] <= CTRL_RST;
			ctrl_q[0].enable <= 1'b1;
		end else if (ctl_ok) begin
			ctrl_q[ctl_idx] <= ctl_wdata;
			// Master cannot disable itself, else nothing would run
			if (ctl_idx == MASTER_CTX)
				ctrl_q[0].enable <= 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			prot_q <= PRIO_RST;
		end else if (prot_ok) begin
			prot_q <= prot_wdata;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			blocked_q <= 1'b0;
		end else begin
			blocked_q <= (ctl_we && !ctl_ok) || (prot_we && !prot_ok);
		end
	end

	// ============================================================
	// Context states
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			for (int c = 0; c < N_CTX; c++)
				state_q[c] <= ST_NOT_READY;
			state_q[0] <= ST_READY;
		end else begin
			for (int c = 0; c < N_CTX; c++) begin
				if (ctl_ok && ctl_idx == CTX_W'(c)) begin
					// master write sets or clears halt
					state_q[c] <= ctl_wdata.halt ? ST_HALTED : ST_READY;
				end else if (dbg_rel_q && dbg_idx_q == CTX_W'(c) &&
				             state_q[c] == ST_HALTED) begin
					state_q[c] <= ST_READY;
				end else if (sleep_exec && run_q == CTX_W'(c) &&
				             state_q[c] == ST_READY && !pend[c]) begin
					// sleep releases the unit; a pending irq wins
					state_q[c] <= ST_NOT_READY;
				end else if (pend[c] && state_q[c] == ST_NOT_READY) begin
					state_q[c] <= ST_READY;
				end
			end
		end
	end

	// ============================================================
	// Entry kind for the winner
	logic win_other;
	logic win_pend;
	hcs_ctx_type_t win_type;
	logic win_outranks;
	assign win_type  = ctrl_q[win].ctype;
	assign win_pend  = pend[win];
	assign win_other = found && (win != run_q || win_pend);
	// Interrupt outranks the context when its priority exceeds it
	assign win_outranks = pend_prio[win] > ctrl_q[win].prio;

	// A running single-thread context has no handler to enter, so its
	// own pending source must not keep raising switches into itself
	logic self_hold;
	assign self_hold = (win == run_q) &&
	                   (in_handler_q[win] || win_type == TYPE_SINGLE_THREAD);

	// Switch handed over to the execution unit this cycle
	logic take;
	assign take = req_q.valid && switch_ack;

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			req_q <= '0;
		end else if (req_q.valid) begin
			if (switch_ack)
				req_q <= '0;
		end else if (win_other && !self_hold) begin
			// request carries context, vector number and entry kind, no register spill
			req_q.valid   <= 1'b1;
			req_q.ctx     <= win;
			req_q.vec_num <= pend_vec[win];
			unique case (win_type)
				TYPE_STANDARD: begin
					// vector fetch, frame push when outranking
					req_q.load_vec   <= win_pend;
					req_q.push_frame <= win_pend && win_outranks;
				end
				TYPE_FAST_VECT: begin
					req_q.load_vec   <= win_pend;
					req_q.push_frame <= 1'b0;
				end
				TYPE_SINGLE_THREAD: begin
					req_q.load_vec   <= 1'b0;
					req_q.push_frame <= 1'b0;
				end
				default: begin
					req_q.load_vec   <= 1'b0;
					req_q.push_frame <= 1'b0;
				end
			endcase
		end
	end

	// ============================================================
	// Running context and handler nesting
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			run_q <= MASTER_CTX;
		end else if (take) begin
			run_q <= req_q.ctx;
		end
	end

	// Handler flag: set on a vectored entry, cleared by return
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			in_handler_q <= '0;
		end else begin
			if (take && req_q.load_vec)
				in_handler_q[req_q.ctx] <= 1'b1;
			if (irq_return && !take)
				in_handler_q[run_q] <= 1'b0;
		end
	end

	// Frame depth: pushed on an outranking entry, popped on return
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			depth_q <= '0;
		end else if (take && req_q.push_frame) begin
			depth_q[req_q.ctx] <= depth_q[req_q.ctx] + 1'b1;
		end else if (irq_return && !take && depth_q[run_q] != '0) begin
			depth_q[run_q] <= depth_q[run_q] - 1'b1;
		end
	end

	assign switch_req    = req_q;
	assign run_ctx       = run_q;
	assign prot_field    = prot_q;
	assign write_blocked = blocked_q;

endmodule

`default_nettype wire

// [hcs_sched_props.sv]
`timescale 1ns/1ps
`default_nettype none
module hcs_sched_props
	import hcs_pkg::*;
#(
	parameter int N_CTX = NUM_CTX
) (
	input wire logic                    mclk,
	input wire logic                    rst_n,
	input wire logic                    ctl_we,
	input wire logic [SW_W-1:0]         cur_status_word,
	input wire logic                    prot_we,
	input wire logic [PRIO_W-1:0]       prot_wdata,
	input wire logic                    switch_ack,
	input wire hcs_switch_t             switch_req,
	input wire logic [CTX_W-1:0]        run_ctx,
	input wire logic [N_CTX-1:0][1:0]   ctx_state,
	input wire logic [PRIO_W-1:0]       prot_field,
	input wire logic                    write_blocked
);
	// ====================
	// Checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	logic sv_ok;
	assign sv_ok = run_ctx == MASTER_CTX && cur_status_word[SUPV_BIT];
	start_master_a: assert property ($rose(rst_n) |-> run_ctx == 3'h0
		&& ctx_state[0] == ST_READY) else $error("not in master");
	refuse_write_a: assert property (ctl_we && run_ctx != 3'h0
		|=> write_blocked) else $error("write not refused");
	accept_write_a: assert property (ctl_we && !prot_we && run_ctx == 3'h0
		|=> !write_blocked) else $error("master write refused");
	prot_keep_a: assert property (prot_we && !sv_ok
		|=> $stable(prot_field)) else $error("guarded field changed");
	prot_load_a: assert property (prot_we && sv_ok
		|=> prot_field == $past(prot_wdata)) else $error("field not written");
	req_hold_a: assert property (switch_req.valid && !switch_ack
		|=> $stable(switch_req)) else $error("request dropped");
	req_done_a: assert property (switch_req.valid && switch_ack
		|=> !switch_req.valid && run_ctx == $past(switch_req.ctx))
		else $error("switch not taken");
	stack_vec_a: assert property (switch_req.valid && switch_req.push_frame
		|-> switch_req.load_vec) else $error("push without vector");
	skip_halt_a: assert property ($rose(switch_req.valid)
		|-> ctx_state[switch_req.ctx] != ST_HALTED) else $error("halted run");
	cover property (switch_req.valid && switch_ack);
	cover property (ctl_we && run_ctx != 3'h0);
	cover property (switch_req.valid && !switch_req.load_vec);
endmodule
bind hcs_sched hcs_sched_props #(.N_CTX(N_CTX)) u_props (.mclk(mclk),
	.rst_n(rst_n), .ctl_we(ctl_we), .cur_status_word(cur_status_word),
	.prot_we(prot_we), .prot_wdata(prot_wdata), .switch_ack(switch_ack),
	.switch_req(switch_req), .run_ctx(run_ctx), .ctx_state(ctx_state),
	.prot_field(prot_field), .write_blocked(write_blocked));
`default_nettype wire

// [hcs_eu_model.sv]
`timescale 1ns/1ps
`default_nettype none
module hcs_eu_model
	import hcs_pkg::*;
(
	input wire logic        mclk,
	input wire hcs_switch_t switch_req,
	input wire logic [3:0]  delay,
	output logic            switch_ack
);
	// ====================
	// Execution unit
	logic [3:0] wait_q;
	initial begin
		switch_ack = 1'b0;
		wait_q = 4'h0;
	end
	// Slow answers stall the switch; a one-cycle ack avoids double takes
	always @(negedge mclk) begin
		if (switch_ack || !switch_req.valid) begin
			switch_ack <= 1'b0;
			wait_q <= 4'h0;
		end else if (wait_q >= delay) begin
			switch_ack <= 1'b1;
		end else begin
			wait_q <= wait_q + 4'h1;
		end
	end
endmodule
`default_nettype wire

// [hcs_sched_test.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin total_checks++; if ((s) !== (e)) begin \
	miscompares++; $display("BAD %s exp %0h got %0h", nm, e, s); end end
module hcs_sched_test;
	import hcs_pkg::*;
	// ====================
	// Bench state
	logic mclk, rst_n, ctl_we, prot_we, sleep_exec, irq_return, dbg_release;
	logic switch_ack, write_blocked;
	logic [15:0] irq_req, cur_status_word;
	logic [15:0][2:0] irq_ctx, irq_prio;
	logic [2:0] ctl_idx, prot_wdata, dbg_idx, run_ctx, prot_field, ep, cp;
	logic [3:0] delay, s;
	hcs_ctx_ctrl_t ctl_wdata;
	hcs_switch_t switch_req;
	hcs_ctx_type_t t;
	logic [4:0][1:0] ctx_state;
	logic [4:0][15:0] saved_frames, ef;
	logic [31:0] seed = 32'h0000f141;
	int miscompares = 0;
	int total_checks = 0;
	hcs_sched dut (.mclk(mclk), .rst_n(rst_n), .irq_req(irq_req),
		.irq_ctx(irq_ctx), .irq_prio(irq_prio), .ctl_we(ctl_we),
		.ctl_idx(ctl_idx), .ctl_wdata(ctl_wdata),
		.cur_status_word(cur_status_word), .prot_we(prot_we),
		.prot_wdata(prot_wdata), .sleep_exec(sleep_exec),
		.irq_return(irq_return), .switch_ack(switch_ack),
		.dbg_release(dbg_release), .dbg_idx(dbg_idx),
		.switch_req(switch_req), .run_ctx(run_ctx), .ctx_state(ctx_state),
		.saved_frames(saved_frames), .prot_field(prot_field),
		.write_blocked(write_blocked));
	hcs_eu_model eu (.mclk(mclk), .switch_req(switch_req), .delay(delay),
		.switch_ack(switch_ack));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic tick(int n = 1);
		repeat (n) @(negedge mclk);
	endtask
	task automatic pulse(ref logic p);
		p = 1'b1;
		tick();
		p = 1'b0;
	endtask
	task automatic ctl_wr(logic [2:0] i, hcs_ctx_ctrl_t w);
		ctl_idx = i;
		ctl_wdata = w;
		pulse(ctl_we);
	endtask
	task automatic prot_wr(logic [15:0] sw, logic [2:0] d);
		cur_status_word = sw;
		prot_wdata = d;
		pulse(prot_we);
		tick();
	endtask
	// Bounded wait for the request, then for the handover
	task automatic enter(logic [2:0] c, logic lv, logic pf, logic [3:0] v);
		int n = 0;
		delay = rnd() % 4;
		while (switch_req.valid !== 1'b1 && n < 60) begin
			tick();
			n++;
		end
		`CHK("req", 1'b1, switch_req.valid)
		`CHK("ctx", c, switch_req.ctx)
		`CHK("load", lv, switch_req.load_vec)
		`CHK("push", pf, switch_req.push_frame)
		`CHK("vec", v, switch_req.vec_num)
		while (run_ctx !== c && n < 90) begin
			tick();
			n++;
		end
		`CHK("run", c, run_ctx)
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	initial begin
		#50000;
		miscompares++;
		conclude();
	end
	// ====================
	// Scenarios
	initial begin
		{rst_n, ctl_we, prot_we, sleep_exec, irq_return, dbg_release} = '0;
		{irq_req, cur_status_word, ctl_idx, prot_wdata, dbg_idx} = '0;
		{ctl_wdata, delay, ef} = '0;
		ep = 3'h0;
		for (int i = 0; i < 16; i++) begin
			irq_ctx[i] = i % 4;
			irq_prio[i] = rnd();
		end
		irq_ctx[14] = 3'h4;
		irq_ctx[15] = 3'h0;
		irq_prio[15] = 3'h0;
		tick(4);
		rst_n = 1'b1;
		tick();
		`CHK("run0", 3'h0, run_ctx)
		`CHK("st4", ST_NOT_READY, ctx_state[4])
		ctl_wr(3'h4, '{1'b1, TYPE_SINGLE_THREAD, 3'h7, 1'b1});
		tick();
		`CHK("halt", ST_HALTED, ctx_state[4])
		irq_req[14] = 1'b1;
		for (int c = 1; c < 4; c++) begin
			t = hcs_ctx_type_t'(c % 3);
			cp = rnd();
			s = rnd() % 3 * 4 + c;
			if (c == 3) begin
				cp = 3'h0;
				irq_prio[s] = 3'h5;
			end
			cur_status_word = rnd();
			if (c == 1)
				cur_status_word[13] = 1'b1;
			if (cur_status_word[13])
				ep = cur_status_word[2:0];
			prot_wr(cur_status_word, cur_status_word[2:0]);
			`CHK("prot", ep, prot_field)
			ctl_wr(c, '{1'b1, t, cp, 1'b0});
			tick();
			`CHK("rdy", ST_READY, ctx_state[c])
			irq_req[s] = 1'b1;
			pulse(sleep_exec);
			ef[c] += (t == TYPE_STANDARD && irq_prio[s] > cp);
			enter(c, t != TYPE_SINGLE_THREAD, ef[c][0], s);
			`CHK("frames", ef[c], saved_frames[c])
			ctl_wr(3'h4, '0);
			`CHK("blk", 1'b1, write_blocked)
			prot_wr(16'h2000, ~ep);
			`CHK("prot_nm", ep, prot_field)
			irq_req[s] = 1'b0;
			pulse(irq_return);
			pulse(sleep_exec);
			tick();
			`CHK("sleep", ST_NOT_READY, ctx_state[c])
			`CHK("pop", 16'h0, saved_frames[c])
			irq_req[15] = 1'b1;
			enter(3'h0, 1'b1, 1'b0, 4'hf);
			irq_req[15] = 1'b0;
			pulse(irq_return);
		end
		`CHK("st4b", ST_HALTED, ctx_state[4])
		ctl_wr(3'h1, '0);
		irq_req[1] = 1'b1;
		pulse(sleep_exec);
		tick(10);
		`CHK("idle", 1'b0, switch_req.valid)
		dbg_idx = 3'h4;
		pulse(dbg_release);
		enter(3'h4, 1'b0, 1'b0, 4'he);
		conclude();
	end
endmodule
`default_nettype wire
